/* logic/ept_pkg.sv */
// shared constants and types of the protected page state tracker
// assumes a single pclk domain and an apb register port
package ept_pkg;

  // ****************************************
  // sizes
  // ****************************************
  localparam int PAGES = 16;
  localparam int PW = 4;
  localparam int SLOT_PER_PAGE = 4;
  localparam int SW = 6;
  localparam int SLOTS = PAGES * SLOT_PER_PAGE;
  localparam int TAG_W = 8;
  // content buffer is 4K bytes, metadata buffer 128 bytes
  localparam int PAGE_SHIFT = 12;
  localparam int META_SHIFT = 7;

  // ****************************************
  // register map and fields
  // ****************************************
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_SEL = 8'h08;
  localparam logic [7:0] ADDR_PAGE = 8'h0C;
  localparam logic [7:0] ADDR_BUF = 8'h10;
  localparam logic [7:0] ADDR_META = 8'h14;
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_PAGE_LSB = 4;
  localparam int CMD_PAR_LSB = 8;
  localparam int CMD_SLOT_LSB = 12;
  localparam int ST_ERR_BIT = 1;
  localparam int ST_CODE_LSB = 4;
  localparam int PV_SLOT_LSB = 16;
  localparam logic [2:0] RIGHTS_ALL = 3'h7;
  localparam logic [2:0] RIGHTS_NONE = 3'h0;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [3:0] {
    nop_op = 4'h0,
    create_version_page_op = 4'h1,
    block_page_op = 4'h2,
    track_enclave_op = 4'h3,
    writeback_evict_op = 4'h4,
    reload_blocked_op = 4'h5,
    reload_unblocked_op = 4'h6,
    dynamic_allocate_op = 4'h7,
    accept_change_op = 4'h8,
    change_page_type_op = 4'h9,
    create_control_op = 4'hA
  } ept_op_t;

  typedef enum logic [1:0] {
    regular_page_type = 2'h0,
    thread_control_page_type = 2'h1,
    control_page_type = 2'h2,
    version_array_type = 2'h3
  } ept_ptype_t;

  typedef enum logic [3:0] {
    err_none = 4'h0,
    err_state = 4'h1,
    err_slot = 4'h2,
    err_parent = 4'h3,
    err_children = 4'h4,
    err_untracked = 4'h5,
    err_op = 4'h6,
    err_buffer = 4'h7
  } ept_err_t;

  typedef struct packed {
    logic [PW-1:0] parent;
    logic [2:0] rights;
    ept_ptype_t ptype;
    logic pending;
    logic trk_pend;
    logic blocked;
    logic valid;
  } ept_page_t;

  typedef struct packed {
    logic [TAG_W-1:0] tag;
    logic [PW-1:0] parent;
    ept_ptype_t ptype;
    logic used;
  } ept_slot_t;

endpackage : ept_pkg

/* logic/ept_op_if.sv */
// operation request and result path between register port and core
// assumes both ends on pclk
`timescale 1ns/100ps
interface ept_op_if;
  logic req;
  ept_pkg::ept_op_t op;
  logic [ept_pkg::PW-1:0] page;
  logic [ept_pkg::PW-1:0] parent;
  logic [ept_pkg::SW-1:0] slot;
  logic [ept_pkg::TAG_W-1:0] tag;
  logic aligned;
  logic [ept_pkg::PW-1:0] sel;
  ept_pkg::ept_page_t view;
  logic [ept_pkg::SLOT_PER_PAGE-1:0] view_slots;
  logic err;
  ept_pkg::ept_err_t code;
  modport slv (output req, op, page, parent, slot, tag, aligned, sel,
    input view, view_slots, err, code);
  modport core (input req, op, page, parent, slot, tag, aligned, sel,
    output view, view_slots, err, code);
endinterface : ept_op_if

/* logic/ept_apb_slave.sv */
// apb register port: command launch, buffer addresses, state readback
// assumes apb master holding requests until pready
`timescale 1ns/100ps
module ept_apb_slave (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  ept_op_if.slv opi
);
  typedef struct packed {
    logic [ept_pkg::PW-1:0] sel;
    logic [31:0] bufa;
    logic [31:0] meta;
    logic [31:0] rdata;
  } ept_slv_t;
  ept_slv_t s_r;
  ept_slv_t s_nxt;
  logic mapped;
  logic acc_wr;
  logic [31:0] rd;

  assign mapped = paddr == ept_pkg::ADDR_CMD || paddr == ept_pkg::ADDR_STATUS
    || paddr == ept_pkg::ADDR_SEL || paddr == ept_pkg::ADDR_PAGE
    || paddr == ept_pkg::ADDR_BUF || paddr == ept_pkg::ADDR_META;
  assign acc_wr = psel && penable && pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = s_r.rdata;
  // command launches in the access cycle so status is fresh on the next read
  assign opi.req = acc_wr && paddr == ept_pkg::ADDR_CMD;
  assign opi.op = ept_pkg::ept_op_t'(pwdata[ept_pkg::CMD_OP_LSB +: 4]);
  assign opi.page = pwdata[ept_pkg::CMD_PAGE_LSB +: ept_pkg::PW];
  assign opi.parent = pwdata[ept_pkg::CMD_PAR_LSB +: ept_pkg::PW];
  assign opi.slot = pwdata[ept_pkg::CMD_SLOT_LSB +: ept_pkg::SW];
  // weak binding of image to its buffers, stands in for the mac check
  assign opi.tag = s_r.bufa[ept_pkg::PAGE_SHIFT +: ept_pkg::TAG_W]
    ^ s_r.meta[ept_pkg::META_SHIFT +: ept_pkg::TAG_W];
  assign opi.aligned = s_r.bufa[ept_pkg::PAGE_SHIFT-1:0] == '0
    && s_r.meta[ept_pkg::META_SHIFT-1:0] == '0;
  assign opi.sel = s_r.sel;

  always_comb
  begin
    rd = 32'h0000_0000;
    if (paddr == ept_pkg::ADDR_STATUS)
    begin
      rd[ept_pkg::ST_ERR_BIT] = opi.err;
      rd[ept_pkg::ST_CODE_LSB +: 4] = opi.code;
    end
    else if (paddr == ept_pkg::ADDR_SEL)
      rd[ept_pkg::PW-1:0] = s_r.sel;
    else if (paddr == ept_pkg::ADDR_PAGE)
    begin
      rd[$bits(ept_pkg::ept_page_t)-1:0] = opi.view;
      rd[ept_pkg::PV_SLOT_LSB +: ept_pkg::SLOT_PER_PAGE] = opi.view_slots;
    end
    else if (paddr == ept_pkg::ADDR_BUF)
      rd = s_r.bufa;
    else if (paddr == ept_pkg::ADDR_META)
      rd = s_r.meta;
    s_nxt = s_r;
    if (psel && !penable && !pwrite)
      s_nxt.rdata = rd;
    if (acc_wr && paddr == ept_pkg::ADDR_SEL)
      s_nxt.sel = pwdata[ept_pkg::PW-1:0];
    if (acc_wr && paddr == ept_pkg::ADDR_BUF)
      s_nxt.bufa = pwdata;
    if (acc_wr && paddr == ept_pkg::ADDR_META)
      s_nxt.meta = pwdata;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end
endmodule : ept_apb_slave

/* logic/ept_access_check.sv */
// access filter: decides whether an enclave access to a page faults
// assumes page state vector from the tracker core
`timescale 1ns/100ps
module ept_access_check (
  input wire logic pclk,
  input wire logic presetn,
  input ept_pkg::ept_page_t [ept_pkg::PAGES-1:0] pages,
  input wire logic acc_valid,
  input wire logic [ept_pkg::PW-1:0] acc_page,
  input wire logic acc_tlb_hit,
  output logic acc_fault,
  output logic acc_grant
);
  typedef struct packed {
    logic fault;
    logic grant;
  } ept_acc_t;
  ept_acc_t s_r;
  ept_acc_t s_nxt;
  ept_pkg::ept_page_t p;

  assign acc_fault = s_r.fault;
  assign acc_grant = s_r.grant;

  always_comb
  begin
    p = pages[acc_page];
    s_nxt = '0;
    if (acc_valid)
    begin
      s_nxt.fault = !p.valid
        || p.pending
        || (p.blocked && !acc_tlb_hit)
        || p.rights == ept_pkg::RIGHTS_NONE
        || p.ptype != ept_pkg::regular_page_type;
      s_nxt.grant = !s_nxt.fault;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end
endmodule : ept_access_check

/* logic/ept_tracker.sv */
// top of the protected page cache state tracker: page states,
// version slots and the paging / allocation operation checks
// assumes software issues one operation per apb write to the command word
//
// The APB slave port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
module ept_tracker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic acc_valid,
  input wire logic [ept_pkg::PW-1:0] acc_page,
  input wire logic acc_tlb_hit,
  output logic acc_fault,
  output logic acc_grant,
  output logic zero_req,
  output logic [ept_pkg::PW-1:0] zero_page
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    ept_pkg::ept_page_t [ept_pkg::PAGES-1:0] pg;
    ept_pkg::ept_slot_t [ept_pkg::SLOTS-1:0] sl;
    logic err;
    ept_pkg::ept_err_t code;
    logic zero;
    logic [ept_pkg::PW-1:0] zpage;
  } ept_core_t;

  ept_core_t s_r;
  ept_core_t s_nxt;
  ept_op_if opi ();

  ept_pkg::ept_page_t tgt;
  ept_pkg::ept_page_t par;
  ept_pkg::ept_page_t vap;
  ept_pkg::ept_slot_t rec;
  ept_pkg::ept_err_t e;
  logic [ept_pkg::PW-1:0] va_idx;
  logic children;
  logic slot_ok;

  // ****************************************
  // register port and access filter
  // ****************************************
  ept_apb_slave u_apb (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .opi(opi)
  );

  ept_access_check u_acc (
    .pclk(pclk),
    .presetn(presetn),
    .pages(s_r.pg),
    .acc_valid(acc_valid),
    .acc_page(acc_page),
    .acc_tlb_hit(acc_tlb_hit),
    .acc_fault(acc_fault),
    .acc_grant(acc_grant)
  );

  assign opi.view = s_r.pg[opi.sel];
  assign opi.err = s_r.err;
  assign opi.code = s_r.code;
  assign zero_req = s_r.zero;
  assign zero_page = s_r.zpage;

  generate
    for (genvar k = 0; k < ept_pkg::SLOT_PER_PAGE; k++)
    begin : g_view
      assign opi.view_slots[k] = s_r.sl[{opi.sel, 2'(k)}].used;
    end
  endgenerate

  // ****************************************
  // operand lookup
  // ****************************************
  always_comb
  begin
    tgt = s_r.pg[opi.page];
    par = s_r.pg[opi.parent];
    va_idx = opi.slot[ept_pkg::SW-1:ept_pkg::SW-ept_pkg::PW];
    vap = s_r.pg[va_idx];
    rec = s_r.sl[opi.slot];
    children = 1'b0;
    for (int i = 0; i < ept_pkg::PAGES; i++)
    begin
      if (s_r.pg[i].valid && s_r.pg[i].parent == opi.page
          && s_r.pg[i].ptype != ept_pkg::control_page_type
          && s_r.pg[i].ptype != ept_pkg::version_array_type)
        children = 1'b1;
    end
    // slot must sit in a resident version page
    slot_ok = vap.valid && vap.ptype == ept_pkg::version_array_type;
  end

  // ****************************************
  // operation execution
  // ****************************************
  // every branch writes state only once all checks passed, so a refused
  // operation leaves pages and slots exactly as they were
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.zero = 1'b0;
    e = ept_pkg::err_none;
    if (opi.req)
    begin
      case (opi.op)
        ept_pkg::create_version_page_op:
        begin
          if (tgt.valid)
            e = ept_pkg::err_state;
          else
          begin
            s_nxt.pg[opi.page] = '0;
            s_nxt.pg[opi.page].valid = 1'b1;
            s_nxt.pg[opi.page].ptype = ept_pkg::version_array_type;
            for (int k = 0; k < ept_pkg::SLOT_PER_PAGE; k++)
              s_nxt.sl[{opi.page, 2'(k)}] = '0;
          end
        end
        ept_pkg::create_control_op:
        begin
          if (tgt.valid)
            e = ept_pkg::err_state;
          else
          begin
            s_nxt.pg[opi.page] = '0;
            s_nxt.pg[opi.page].valid = 1'b1;
            s_nxt.pg[opi.page].ptype = ept_pkg::control_page_type;
            s_nxt.pg[opi.page].parent = opi.page;
          end
        end
        ept_pkg::block_page_op:
        begin
          if (!tgt.valid || tgt.blocked
              || tgt.ptype == ept_pkg::control_page_type
              || tgt.ptype == ept_pkg::version_array_type)
            e = ept_pkg::err_state;
          else
          begin
            s_nxt.pg[opi.page].blocked = 1'b1;
            s_nxt.pg[opi.page].trk_pend = 1'b1;
          end
        end
        ept_pkg::track_enclave_op:
        begin
          if (!tgt.valid || tgt.ptype != ept_pkg::control_page_type)
            e = ept_pkg::err_state;
          else
          begin
            for (int i = 0; i < ept_pkg::PAGES; i++)
            begin
              if (s_r.pg[i].valid && s_r.pg[i].blocked
                  && s_r.pg[i].parent == opi.page)
                s_nxt.pg[i].trk_pend = 1'b0;
            end
          end
        end
        ept_pkg::writeback_evict_op:
        begin
          if (!tgt.valid)
            e = ept_pkg::err_state;
          else if (!slot_ok || rec.used || va_idx == opi.page)
            e = ept_pkg::err_slot;
          else if (!opi.aligned)
            e = ept_pkg::err_buffer;
          else if (tgt.ptype == ept_pkg::control_page_type && children)
            e = ept_pkg::err_children;
          else if ((tgt.ptype == ept_pkg::regular_page_type
              || tgt.ptype == ept_pkg::thread_control_page_type)
              && !tgt.blocked)
            e = ept_pkg::err_state;
          else if ((tgt.ptype == ept_pkg::regular_page_type
              || tgt.ptype == ept_pkg::thread_control_page_type)
              && tgt.trk_pend)
            e = ept_pkg::err_untracked;
          else
          begin
            s_nxt.sl[opi.slot].used = 1'b1;
            s_nxt.sl[opi.slot].ptype = tgt.ptype;
            s_nxt.sl[opi.slot].parent = tgt.parent;
            s_nxt.sl[opi.slot].tag = opi.tag;
            s_nxt.pg[opi.page] = '0;
          end
        end
        ept_pkg::reload_blocked_op,
        ept_pkg::reload_unblocked_op:
        begin
          if (tgt.valid)
            e = ept_pkg::err_state;
          else if (!slot_ok || !rec.used)
            e = ept_pkg::err_slot;
          else if (!opi.aligned || rec.tag != opi.tag)
            e = ept_pkg::err_buffer;
          else if ((rec.ptype == ept_pkg::regular_page_type
              || rec.ptype == ept_pkg::thread_control_page_type)
              && (!par.valid || par.ptype != ept_pkg::control_page_type
              || opi.parent != rec.parent))
            e = ept_pkg::err_parent;
          else
          begin
            s_nxt.pg[opi.page] = '0;
            s_nxt.pg[opi.page].valid = 1'b1;
            s_nxt.pg[opi.page].ptype = rec.ptype;
            s_nxt.pg[opi.page].parent =
              rec.ptype == ept_pkg::control_page_type ? opi.page : rec.parent;
            s_nxt.pg[opi.page].rights =
              rec.ptype == ept_pkg::regular_page_type ? ept_pkg::RIGHTS_ALL
                                                      : ept_pkg::RIGHTS_NONE;
            s_nxt.pg[opi.page].blocked =
              opi.op == ept_pkg::reload_blocked_op;
            s_nxt.sl[opi.slot] = '0;
          end
        end
        ept_pkg::dynamic_allocate_op:
        begin
          if (tgt.valid)
            e = ept_pkg::err_state;
          else if (!par.valid || par.ptype != ept_pkg::control_page_type)
            e = ept_pkg::err_parent;
          else
          begin
            s_nxt.pg[opi.page] = '0;
            s_nxt.pg[opi.page].valid = 1'b1;
            s_nxt.pg[opi.page].pending = 1'b1;
            s_nxt.pg[opi.page].ptype = ept_pkg::regular_page_type;
            s_nxt.pg[opi.page].rights = ept_pkg::RIGHTS_ALL;
            s_nxt.pg[opi.page].parent = opi.parent;
            s_nxt.zero = 1'b1;
            s_nxt.zpage = opi.page;
          end
        end
        ept_pkg::accept_change_op:
        begin
          // expected type travels in the low slot bits
          if (!tgt.valid || !tgt.pending || tgt.blocked
              || tgt.ptype != ept_pkg::ept_ptype_t'(opi.slot[1:0]))
            e = ept_pkg::err_state;
          else
            s_nxt.pg[opi.page].pending = 1'b0;
        end
        ept_pkg::change_page_type_op:
        begin
          if (!tgt.valid || tgt.pending || tgt.blocked
              || tgt.ptype != ept_pkg::regular_page_type
              || opi.slot[1:0] != ept_pkg::thread_control_page_type)
            e = ept_pkg::err_state;
          else
          begin
            s_nxt.pg[opi.page].ptype = ept_pkg::thread_control_page_type;
            s_nxt.pg[opi.page].rights = ept_pkg::RIGHTS_NONE;
            s_nxt.pg[opi.page].pending = 1'b1;
          end
        end
        default:
        begin
          e = ept_pkg::err_op;
        end
      endcase
      s_nxt.err = e != ept_pkg::err_none;
      s_nxt.code = e;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

endmodule : ept_tracker

/* testbench/ept_props.sv */
// port checker for the page state tracker
// assumes binding onto ept_tracker, single pclk domain
`timescale 1ns/100ps
module ept_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic acc_valid,
  input wire logic [ept_pkg::PW-1:0] acc_page,
  input wire logic acc_tlb_hit,
  input wire logic acc_fault,
  input wire logic acc_grant,
  input wire logic zero_req,
  input wire logic [ept_pkg::PW-1:0] zero_page
);
  // ****
  // properties
  // ****
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire cmd_wr = psel && penable && pwrite && paddr == ept_pkg::ADDR_CMD;
  a_fault_excl: assert property (acc_fault |-> !acc_grant)
    else $error("fault and grant together");
  a_probe_answer: assert property (acc_valid |=> acc_fault != acc_grant)
    else $error("probe got no single answer");
  a_no_spurious: assert property (!acc_valid |=> !acc_fault && !acc_grant)
    else $error("answer without probe");
  a_zero_pulse: assert property (zero_req |=> !zero_req)
    else $error("zero request longer than one cycle");
  a_zero_cause: assert property (zero_req |->
    $past(cmd_wr && pwdata[3:0] == ept_pkg::dynamic_allocate_op))
    else $error("zero request without allocate");
  a_zero_page: assert property (zero_req |-> zero_page == $past(pwdata[7:4]))
    else $error("zero request names wrong page");
  a_pend_fault: assert property (zero_req && acc_valid && acc_page == zero_page
    |=> acc_fault)
    else $error("fresh page usable before accept");
  a_refuse_quiet: assert property (cmd_wr && pwdata[3:0] > 4'hA |=> !zero_req)
    else $error("refused op had side effect");
  a_err_phase: assert property (pslverr |-> psel && penable)
    else $error("slave error outside access");
endmodule : ept_props

bind ept_tracker ept_props ept_props_i (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .acc_valid, .acc_page, .acc_tlb_hit,
  .acc_fault, .acc_grant, .zero_req, .zero_page);

/* testbench/ept_sw_model.sv */
// paging software model: apb master issuing page operations
// assumes the slave may insert wait states
`timescale 1ns/100ps
module ept_sw_model (
  input wire logic pclk,
  input wire logic pready,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata
);
  // ****
  // bus cycles and sequences
  // ****
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no own limit: a stuck slave is caught by the bench watchdog
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    // released data is scrambled so nothing relies on stale values
    pwdata <= ~d;
  endtask : xfer
  task automatic op(input logic [3:0] o, input logic [3:0] pg, input logic [3:0] par,
    input logic [5:0] sl);
    xfer(1'b1, ept_pkg::ADDR_CMD, {14'h0, sl, par, pg, o});
  endtask : op
  // unmap assumed done; block, track the owner, then evict
  task automatic evict_seq(input logic [3:0] pg, input logic [3:0] par, input logic [5:0] sl);
    op(ept_pkg::block_page_op, pg, par, 6'h0);
    op(ept_pkg::track_enclave_op, par, 4'h0, 6'h0);
    op(ept_pkg::writeback_evict_op, pg, par, sl);
  endtask : evict_seq
  // parent must already be resident when a child comes back
  task automatic reload(input logic blk, input logic [3:0] pg, input logic [3:0] par,
    input logic [5:0] sl);
    op(blk ? 4'h5 : 4'h6, pg, par, sl);
  endtask : reload
endmodule : ept_sw_model

/* testbench/enclave_page_state_tracker_tb.sv */
// self-checking bench of the page state tracker
// assumes ept_sw_model as bus master, probes driven here
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin bad_count++; \
  $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module enclave_page_state_tracker_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic acc_valid = 1'b0;
  logic [3:0] acc_page = 4'h0;
  logic acc_tlb_hit = 1'b0;
  logic acc_fault, acc_grant, zero_req;
  logic [3:0] zero_page;
  logic [63:0] rd_q[$];
  logic [1:0] pr_q[$];
  logic [63:0] e;
  logic [1:0] pe;
  logic probe_d = 1'b0;
  logic [31:0] seed = 32'h3B112116;
  logic [3:0] bad_ops [6] = '{4'h0, 4'hB, 4'hC, 4'hD, 4'hE, 4'hF};
  int bad_count = 0;
  int compares = 0;
  always #2.5 pclk = ~pclk;
  ept_tracker ept_tracker_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .acc_valid, .acc_page, .acc_tlb_hit,
    .acc_fault, .acc_grant, .zero_req, .zero_page);
  ept_sw_model ept_sw_model_i (.pclk, .pready, .psel, .penable, .pwrite, .paddr, .pwdata);
  // ****
  // result watcher
  // ****
  always @(posedge pclk)
  begin
    if (probe_d)
    begin
      pe = pr_q.pop_front();
      `CHK("probe", pe, {acc_fault, acc_grant})
    end
    probe_d = acc_valid;
    // 8'h40 is the only unmapped address this bench uses
    if (psel && penable && pready)
      `CHK("pslverr", paddr == 8'h40, pslverr)
    if (psel && penable && !pwrite && pready)
    begin
      e = rd_q.pop_front();
      `CHK("read", e[31:0], prdata & e[63:32])
    end
  end
  // ****
  // helpers
  // ****
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    rd_q.push_back({m, x & m});
    ept_sw_model_i.xfer(1'b0, a, 32'h0);
  endtask : rd
  task automatic o(input logic [3:0] c, input logic [3:0] pg, input logic [3:0] par,
    input logic [5:0] sl);
    ept_sw_model_i.op(c, pg, par, sl);
  endtask : o
  task automatic er(input logic [3:0] c);
    rd(ept_pkg::ADDR_STATUS, 32'hF2, {24'h0, c, 2'b00, c != 4'h0, 1'b0});
  endtask : er
  task automatic pg(input logic [3:0] p, input logic [31:0] m, input logic [31:0] x);
    ept_sw_model_i.xfer(1'b1, ept_pkg::ADDR_SEL, {28'h0, p});
    rd(ept_pkg::ADDR_PAGE, m, x);
  endtask : pg
  task automatic probe(input logic [3:0] p, input logic hit, input int n, input logic [1:0] x);
    repeat (n)
    begin
      @(posedge pclk);
      acc_valid <= 1'b1;
      acc_page <= p;
      acc_tlb_hit <= hit;
      pr_q.push_back(x);
    end
    @(posedge pclk);
    acc_valid <= 1'b0;
  endtask : probe
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : test_done
  // ****
  // scenarios
  // ****
  initial
  begin
    #50000;
    bad_count++;
    test_done();
  end
  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    er(4'h0);
    pg(4'h0, 32'hF1FFF, 32'h0);
    rd(8'h40, 32'hFFFFFFFF, 32'h0);
    repeat (4)
    begin
      seed = lfsr(seed);
      ept_sw_model_i.xfer(1'b1, ept_pkg::ADDR_SEL, seed);
      rd(ept_pkg::ADDR_SEL, 32'hF, seed);
    end
    ept_sw_model_i.xfer(1'b1, ept_pkg::ADDR_BUF, {seed[31:12], 12'h0});
    ept_sw_model_i.xfer(1'b1, ept_pkg::ADDR_META, {seed[31:7], 7'h0});
    $display("test registers done");
    o(4'hA, 4'h0, 4'h0, 6'h0);
    fork
      o(4'h7, 4'h1, 4'h0, 6'h0);
      probe(4'h1, 1'b0, 8, 2'b10);
    join
    er(4'h0);
    pg(4'h1, 32'h1E3B, 32'h9);
    o(4'h7, 4'h1, 4'h0, 6'h0);
    er(4'h1);
    pg(4'h1, 32'h1E3B, 32'h9);
    probe(4'h1, 1'b1, 1, 2'b10);
    o(4'h8, 4'h1, 4'h0, 6'h0);
    er(4'h0);
    pg(4'h1, 32'h8, 32'h0);
    o(4'h9, 4'h1, 4'h0, 6'h1);
    er(4'h0);
    pg(4'h1, 32'h1F0, 32'h10);
    o(4'h8, 4'h1, 4'h0, 6'h1);
    er(4'h0);
    probe(4'h1, 1'b1, 1, 2'b10);
    $display("test allocation done");
    o(4'h1, 4'h2, 4'h0, 6'h0);
    o(4'h7, 4'h3, 4'h0, 6'h0);
    o(4'h8, 4'h3, 4'h0, 6'h0);
    o(4'h4, 4'h3, 4'h0, 6'h08);
    rd(ept_pkg::ADDR_STATUS, 32'h2, 32'h2);
    o(4'h2, 4'h3, 4'h0, 6'h0);
    pg(4'h3, 32'h2, 32'h2);
    probe(4'h3, 1'b0, 1, 2'b10);
    o(4'h4, 4'h3, 4'h0, 6'h08);
    er(4'h5);
    ept_sw_model_i.xfer(1'b1, ept_pkg::ADDR_BUF, 32'h123);
    o(4'h3, 4'h0, 4'h0, 6'h0);
    o(4'h4, 4'h3, 4'h0, 6'h08);
    er(4'h7);
    ept_sw_model_i.xfer(1'b1, ept_pkg::ADDR_BUF, {seed[31:12], 12'h0});
    o(4'h4, 4'h3, 4'h0, 6'h08);
    er(4'h0);
    pg(4'h3, 32'h1, 32'h0);
    pg(4'h2, 32'hF0000, 32'h10000);
    o(4'h4, 4'h0, 4'h0, 6'h09);
    er(4'h4);
    o(4'h4, 4'h2, 4'h0, 6'h0A);
    er(4'h2);
    ept_sw_model_i.reload(1'b0, 4'h3, 4'h0, 6'h08);
    er(4'h0);
    pg(4'h3, 32'hF, 32'h1);
    pg(4'h2, 32'hF0000, 32'h0);
    probe(4'h3, 1'b1, 1, 2'b01);
    ept_sw_model_i.evict_seq(4'h3, 4'h0, 6'h09);
    er(4'h0);
    ept_sw_model_i.reload(1'b1, 4'h3, 4'h0, 6'h08);
    er(4'h2);
    ept_sw_model_i.reload(1'b1, 4'h3, 4'h0, 6'h09);
    er(4'h0);
    pg(4'h3, 32'h3, 32'h3);
    $display("test paging done");
    foreach (bad_ops[i])
    begin
      o(bad_ops[i], 4'h5, 4'h0, 6'h0);
      er(4'h6);
    end
    $display("test bad codes done");
    repeat (4) @(posedge pclk);
    test_done();
  end
endmodule : enclave_page_state_tracker_tb
